// ===== rtl/setp_pkg.sv
// Shared constants and types of the two-wire serial memory target engine.
package setp_pkg;

   // ---------------------------------------------------------------
   // Device selection and word framing
   // ---------------------------------------------------------------
   localparam logic [3:0] TYPE_CODE     = 4'hA;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;
   localparam int         PAGE_BITS     = 3;
   localparam int         MEM_WORDS     = 256;
   localparam logic [7:0] ADDR_RESET    = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ     = 50;
   localparam int WR_TIME_US  = 5000;
   localparam int WR_CYCLES   = WR_TIME_US * CLK_MHZ;
   localparam int FIFO_DEPTH  = 16;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV  = 3'h1,
      ST_WADR = 3'h3,
      ST_WDAT = 3'h2,
      ST_RDAT = 3'h6
   } setp_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } setp_wr_t;

endpackage : setp_pkg

// ===== rtl/setp_fifo.sv
// First-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module setp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              do_push;
   wire              do_pop;

   // ---------------------------------------------------------------
   // Flags
   // ---------------------------------------------------------------
   // Full when pointers differ only in the wrap bit, empty when equal.
   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;
   assign out_data  = store[rd_ptr[AW-1:0]];

   // Pointers advance on accepted transfers only.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge ref_clk) begin
      if (do_push) store[wr_ptr[AW-1:0]] <= in_data;
   end

endmodule : setp_fifo
`default_nettype wire

// ===== rtl/setp_target.sv
// Target-side two-wire protocol engine with a 256-byte array.
`timescale 1ns/100ps
`default_nettype none
module setp_target #(
   parameter int WR_CYCLES  = setp_pkg::WR_CYCLES,
   parameter int FIFO_DEPTH = setp_pkg::FIFO_DEPTH
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   output logic      write_busy
);
   import setp_pkg::*;

   localparam int TW = $clog2(WR_CYCLES + 1);
   localparam logic [TW-1:0] TIMER_LOAD = TW'(WR_CYCLES - 1);

   logic              scl_m, scl_s, scl_q;
   logic              sda_m, sda_s, sda_q;
   setp_state_t       st;
   logic [3:0]        cnt;
   logic              in_ack;
   logic              rw;
   logic              mack;
   logic [7:0]        shreg;
   logic [7:0]        tx;
   logic [7:0]        addr;
   logic [7:0]        mem_q;
   logic [7:0]        mem_array [MEM_WORDS];
   logic              busy;
   logic              wr_pend;
   logic [TW-1:0]     timer;
   setp_wr_t          push_word;
   setp_wr_t          drain_word;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [$bits(setp_wr_t)-1:0] fifo_out_data;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Two flops per pin, then one more stage for edge detection.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         {scl_m, scl_s, scl_q} <= 3'h7;
         {sda_m, sda_s, sda_q} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
      end
   end

   // ---------------------------------------------------------------
   // Bus event decode
   // ---------------------------------------------------------------
   wire start_det  = scl_s && scl_q && sda_q && !sda_s;
   wire stop_det   = scl_s && scl_q && !sda_q && sda_s;
   wire scl_rise   = scl_s && !scl_q;
   wire scl_fall   = !scl_s && scl_q;
   wire rx_state   = (st == ST_DEV) || (st == ST_WADR) || (st == ST_WDAT);
   wire word_end   = rx_state && !in_ack && scl_fall && (cnt == BITS_PER_WORD);
   wire type_match = (shreg[7:4] == TYPE_CODE);
   wire ack_ok     = ((st == ST_DEV) && type_match) || (st == ST_WADR)
                   || ((st == ST_WDAT) && fifo_in_ready);
   wire push       = word_end && (st == ST_WDAT) && fifo_in_ready;
   wire wc_start   = stop_det && !busy && wr_pend;
   wire [7:0] page_inc = {addr[7:PAGE_BITS], addr[PAGE_BITS-1:0] + 3'h1};
   wire [7:0] tx_shift = {tx[6:0], 1'b0};

   assign sda_out    = 1'b0;
   assign write_busy = busy;
   assign push_word  = '{addr: addr, data: shreg};
   assign drain_word = fifo_out_data;

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   // The output enable pulls the open-drain data line low when set.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st     <= ST_IDLE;
         cnt    <= 4'h0;
         in_ack <= 1'b0;
         sda_oe <= 1'b0;
         rw     <= 1'b0;
         mack   <= 1'b0;
         shreg  <= 8'h00;
         tx     <= 8'h00;
         addr   <= ADDR_RESET;
      end else if (busy) begin
         st     <= ST_IDLE;
         in_ack <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         st     <= ST_DEV;
         cnt    <= 4'h0;
         in_ack <= 1'b0;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         st     <= ST_IDLE;
         in_ack <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         case (st)
            ST_DEV, ST_WADR, ST_WDAT: begin
               if (!in_ack) begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt   <= cnt + 4'h1;
                  end else if (word_end) begin
                     if (ack_ok) begin
                        sda_oe <= 1'b1;
                        in_ack <= 1'b1;
                     end else begin
                        st <= ST_IDLE;
                     end
                     if (st == ST_DEV) rw <= shreg[0];
                     if (st == ST_WADR) addr <= shreg;
                     if (push) addr <= page_inc;
                  end
               end else if (scl_fall) begin
                  in_ack <= 1'b0;
                  cnt    <= 4'h0;
                  sda_oe <= 1'b0;
                  if ((st == ST_DEV) && rw) begin
                     st     <= ST_RDAT;
                     tx     <= mem_q;
                     sda_oe <= !mem_q[7];
                  end else if (st == ST_DEV) begin
                     st <= ST_WADR;
                  end else if (st == ST_WADR) begin
                     st <= ST_WDAT;
                  end
               end
            end
            ST_RDAT: begin
               if (!in_ack) begin
                  if (scl_fall) begin
                     if (cnt == LAST_TX_BIT) begin
                        sda_oe <= 1'b0;
                        in_ack <= 1'b1;
                        addr   <= addr + 8'h01;
                     end else begin
                        tx     <= tx_shift;
                        sda_oe <= !tx[6];
                        cnt    <= cnt + 4'h1;
                     end
                  end
               end else if (scl_rise) begin
                  mack <= !sda_s;
               end else if (scl_fall) begin
                  if (mack) begin
                     tx     <= mem_q;
                     sda_oe <= !mem_q[7];
                     cnt    <= 4'h0;
                     in_ack <= 1'b0;
                  end else begin
                     st <= ST_IDLE;
                  end
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Self-timed write cycle
   // ---------------------------------------------------------------
   // Pending data is committed only by a stop after at least one byte.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_pend <= 1'b0;
      end else if (push) begin
         wr_pend <= 1'b1;
      end else if (wc_start) begin
         wr_pend <= 1'b0;
      end
   end

   // Busy lasts for the timer and until the page buffer has drained.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy  <= 1'b0;
         timer <= '0;
      end else if (wc_start) begin
         busy  <= 1'b1;
         timer <= TIMER_LOAD;
      end else if (busy) begin
         if (timer != '0) timer <= timer - 1'b1;
         else if (!fifo_out_valid) busy <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Page buffer and array
   // ---------------------------------------------------------------
   // Bytes wait here until the stop; draining stalls outside the cycle.
   setp_fifo #(
      .WIDTH ($bits(setp_wr_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_page_buf (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_out_valid),
      .out_ready (busy),
      .out_data  (fifo_out_data)
   );

   // Only received bytes are written; later bytes to a slot win.
   always_ff @(posedge ref_clk) begin
      if (busy && fifo_out_valid) mem_array[drain_word.addr] <= drain_word.data;
      mem_q <= mem_array[addr];
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   busy_no_ack_a: assert property (busy |=> !sda_oe)
      else $error("Data line driven during write cycle.");
   dev_match_a: assert property ((st == ST_DEV) && word_end && type_match
                                 |=> sda_oe && in_ack)
      else $error("Matching address not acknowledged.");
   dev_miss_a: assert property ((st == ST_DEV) && word_end && !type_match
                                |=> !sda_oe && (st == ST_IDLE))
      else $error("Foreign address acknowledged.");
   page_inc_a: assert property (push |=> (addr[7:3] == $past(addr[7:3]))
                                && (addr[2:0] == $past(addr[2:0]) + 3'h1))
      else $error("Page address step wrong.");
   read_inc_a: assert property ((st == ST_RDAT) && !in_ack && scl_fall && (cnt == LAST_TX_BIT)
                                |=> addr == $past(addr) + 8'h01)
      else $error("Read address not advanced.");
   stop_rel_a: assert property (stop_det |=> !sda_oe)
      else $error("Data line held after stop.");
   start_sel_a: assert property (start_det && !busy |=> (st == ST_DEV) && (cnt == 4'h0))
      else $error("Start did not open address phase.");
   wc_begin_a: assert property (wc_start |=> busy ##1 busy)
      else $error("Write cycle did not begin at stop.");
   tx_bit_a: assert property ((st == ST_RDAT) && !in_ack |-> sda_oe == !tx[7])
      else $error("Read bit on line differs from data.");
   rw_sel_a: assert property ((st == ST_DEV) && in_ack && rw && scl_fall
                              |=> st == ST_RDAT)
      else $error("Read bit did not select a read.");

   // Ownership of the data line during acknowledges, and the write cycle.
   ack_hold_a: assert property (rx_state && in_ack |-> sda_oe)
      else $error("Acknowledge not held through the ninth clock.");
   page_ack_a: assert property ((st == ST_WDAT) && word_end && fifo_in_ready |=> sda_oe)
      else $error("Page data byte not acknowledged.");
   rd_release_a: assert property ((st == ST_RDAT) && in_ack |-> !sda_oe)
      else $error("Data line held during controller acknowledge.");
   busy_idle_a: assert property (busy |=> st == ST_IDLE)
      else $error("Protocol engine active during write cycle.");
   timer_run_a: assert property (busy && (timer != '0) |=> busy)
      else $error("Write cycle ended before the timer expired.");

   // Main scenarios: page end, sequential read, polling, cycle end, read wrap.
   page_full_c: cover property (push && (addr[2:0] == 3'h7));
   seq_read_c:  cover property ((st == ST_RDAT) && in_ack && mack && scl_fall);
   poll_nack_c: cover property (busy && start_det);
   wc_done_c:   cover property (busy ##1 !busy);
   rd_wrap_c:   cover property ((st == ST_RDAT) && in_ack && (addr == 8'h00));

endmodule : setp_target
`default_nettype wire

// ===== verif/setp_ctl_model.sv
// Behavioural two-wire bus controller that drives the far side of the target.
`timescale 1ns/100ps
`default_nettype none
module setp_ctl_model (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   // -------------------------------------------------------------
   // Bus idle and bit timing
   // -------------------------------------------------------------
   // Both lines idle high; the clock stands still outside frames.
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   // Waits a number of reference clock edges.
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // Start from idle, or a repeated start from a low clock. The first tick lets a
   // clock level that the caller has just scheduled settle before it is read.
   task automatic start_cond();
      tick(1);
      if (scl == 1'b0) begin
         sda_drv <= 1'b1;
         tick(4);
         scl <= 1'b1;
         tick(4);
      end
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask : start_cond

   // Data rises while the clock is high to end the transfer.
   task automatic stop_cond();
      tick(1);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
   endtask : stop_cond

   // One 160 ns clock: data changes early in the low half, sampled while high.
   task automatic xfer_bit(input logic b, output logic r);
      tick(1);
      sda_drv <= b;
      tick(4);
      scl <= 1'b1;
      tick(2);
      r = sda_line;
      tick(1);
      scl <= 1'b0;
   endtask : xfer_bit

   // Sends a byte most significant bit first and reports the target's answer.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask : put_byte

   // Receives a byte, then acknowledges it only if more are wanted.
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(~more, r);
   endtask : get_byte
endmodule : setp_ctl_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the two-wire serial memory target.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import setp_pkg::*;
   localparam int WR_SIM = 200;
   logic       ref_clk     = 1'b0;
   logic       sys_rst     = 1'b1;
   wire  logic scl;
   wire  logic sda_drv;
   wire  logic sda_out;
   wire  logic sda_oe;
   wire  logic write_busy;
   wire  logic sda_line;
   int         mismatches  = 0;
   int         checks_done = 0;
   logic [7:0] page_q [$];

   // -------------------------------------------------------------
   // Clock, bus wiring and instances
   // -------------------------------------------------------------
   // The data line is pulled up; either party may pull it low.
   always #10 ref_clk = ~ref_clk;
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

   setp_target #(.WR_CYCLES(WR_SIM), .FIFO_DEPTH(FIFO_DEPTH)) uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
   setp_ctl_model ctl (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // Compares one byte and reports a difference at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits a bounded time for the busy flag to reach a level.
   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (write_busy !== lvl && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      chk({7'h00, write_busy}, {7'h00, lvl});
      // A level never reached is already counted by the compare above.
      if (write_busy !== lvl) final_report();
   endtask : wait_busy

   // Full write sequence with every acknowledge checked, ended by a stop.
   task automatic wr_seq(input logic [7:0] dev, input logic [7:0] wa, input logic [7:0] q[$]);
      logic a;
      ctl.start_cond();
      ctl.put_byte(dev, a);
      chk({7'h00, a}, 8'h01);
      ctl.put_byte(wa, a);
      chk({7'h00, a}, 8'h01);
      foreach (q[i]) begin
         ctl.put_byte(q[i], a);
         chk({7'h00, a}, 8'h01);
      end
      ctl.stop_cond();
      wait_busy(1'b1, 10);
      wait_busy(1'b0, WR_SIM + 400);
   endtask : wr_seq

   // Random read (dummy write first) or current read, then a run of bytes.
   task automatic rd_seq(input logic rnd, input logic [7:0] wa, input logic [7:0] exp[$]);
      logic       a;
      logic [7:0] d;
      ctl.start_cond();
      if (rnd) begin
         ctl.put_byte(8'hA0, a);
         chk({7'h00, a}, 8'h01);
         ctl.put_byte(wa, a);
         chk({7'h00, a}, 8'h01);
         ctl.start_cond();
      end
      ctl.put_byte(8'hA1, a);
      chk({7'h00, a}, 8'h01);
      foreach (exp[i]) begin
         ctl.get_byte(i < exp.size() - 1, d);
         chk(d, exp[i]);
      end
      ctl.stop_cond();
      chk({7'h00, sda_oe}, 8'h00);
   endtask : rd_seq

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Write, then poll while busy: no answer until programming ends.
   task automatic s_write_poll();
      logic a;
      ctl.start_cond();
      ctl.put_byte(8'hAE, a);
      chk({7'h00, a}, 8'h01);
      ctl.put_byte(8'hFF, a);
      chk({7'h00, a}, 8'h01);
      ctl.put_byte(8'h5A, a);
      chk({7'h00, a}, 8'h01);
      ctl.stop_cond();
      wait_busy(1'b1, 10);
      ctl.start_cond();
      ctl.put_byte(8'hA0, a);
      chk({7'h00, a}, 8'h00);
      ctl.stop_cond();
      wait_busy(1'b0, WR_SIM + 400);
      ctl.start_cond();
      ctl.put_byte(8'hA0, a);
      chk({7'h00, a}, 8'h01);
      ctl.stop_cond();
      wr_seq(8'hA0, 8'h00, {8'hC3});
   endtask : s_write_poll

   // A foreign type pattern gets no acknowledge.
   task automatic s_wrong_type();
      logic a;
      ctl.start_cond();
      ctl.put_byte(8'hB0, a);
      chk({7'h00, a}, 8'h00);
      ctl.stop_cond();
      chk({7'h00, write_busy}, 8'h00);
   endtask : s_wrong_type

   // Ten bytes from 0x1E wrap inside the page; the counter stays in the page.
   task automatic s_page_write();
      for (int i = 0; i < 10; i++) page_q.push_back(8'h40 + 8'(i));
      wr_seq(8'hA0, 8'h1E, page_q);
      rd_seq(1'b0, 8'h00, {8'h42});
      rd_seq(1'b1, 8'h18, {8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47});
      rd_seq(1'b0, 8'h00, {8'h48, 8'h49});
   endtask : s_page_write

   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   // Resets the design, then runs each scenario in turn.
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      s_write_poll();
      s_wrong_type();
      s_page_write();
      rd_seq(1'b1, 8'hFF, {8'h5A, 8'hC3});
      final_report();
   end

   // Cuts a hang short and counts it as a mismatch.
   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      final_report();
   end
endmodule : tb_top
`default_nettype wire
